// file: flyback_fault_pkg.sv
package flyback_fault_pkg;
   // Clock rate and times in their own units
   localparam int CLK_PERIOD_NS = 40;
   localparam int BLANK_NS      = 420;
   localparam int UV_TIME_MS    = 128;
   localparam int SHORT_TIME_MS = 64;
   localparam int NS_PER_MS     = 1000000;
   // Derived cycle counts: least time rounds up, timeouts round down
   localparam int BLANK_CYCLES =
      (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int UV_CYCLES    = UV_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int SHORT_CYCLES = SHORT_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
   // Consecutive switching-cycle counts before a trip
   localparam int OV_COUNT        = 3;
   localparam int SENSE_MAX_COUNT = 3;
   localparam int BROWN_OUT_COUNT = 3;
   localparam int CYC_CNT_W       = 2;
   localparam int BLANK_W         = 4;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_WAIT_START,
      ST_CHECK_PULSE,
      ST_RUN,
      ST_BROWN_FAIL,
      ST_RECOVER
   } state_t;

   // Latched cause of the last trip
   typedef enum logic [2:0] {
      FAULT_NONE,
      FAULT_SUPPLY_OV,
      FAULT_OVERTEMP,
      FAULT_SHORT,
      FAULT_OUT_UV,
      FAULT_OUT_OV,
      FAULT_SENSE_MAX,
      FAULT_BROWN_OUT
   } fault_t;
endpackage : flyback_fault_pkg

// file: flyback_fault_protection_fsm.sv
`timescale 1ns/100ps

// Operation
// R01 - Supply over-voltage stops drive at once and enters auto-recovery.
// R02 - Three consecutive feedback over-voltage samples trip and recover.
// R03 - Feedback below under-voltage level for 128ms trips and recovers.
// R04 - Feedback below short level for 64ms trips and recovers.
// R05 - Three consecutive pulses over sense maximum shut down and recover.
// R06 - Over-temperature stops switching at once and enters auto-recovery.
// R07 - After over-temperature, no pulse until temperature drops by hysteresis.
// R08 - Recovery waits for minimum supply, then restarts.
// R09 - Bus voltage is sampled every cycle during primary conduction.
// R10 - At start threshold emit one pulse and check bus against brown-in.
// R11 - Failed brown-in stops pulses until supply decays; check repeats.
// R12 - Bus below brown-out on three consecutive cycles shuts down.
// R13 - Line compensation switch closes only during primary on time.
// R14 - Current sense ignored for 420ns after each turn-on.
// R15 - High conduction ratio below under-voltage point during start-up.
// R16 - Restart clears counters and timers; trip state latched until then.
// R17 - A fault timer resets when its condition drops before expiry.
module flyback_fault_protection_fsm #(
   parameter int UV_LIMIT    = flyback_fault_pkg::UV_CYCLES,
   parameter int SHORT_LIMIT = flyback_fault_pkg::SHORT_CYCLES
) (
   input  wire logic                        sys_clk_in,
   input  wire logic                        srst_in,
   input  wire logic                        supply_overvoltage_in,
   input  wire logic                        startup_supply_in,
   input  wire logic                        min_supply_in,
   input  wire logic                        overtemp_in,
   input  wire logic                        temp_recovered_in,
   input  wire logic                        pulse_request_in,
   input  wire logic                        sense_ref_trip_in,
   input  wire logic                        sense_max_in,
   input  wire logic                        fb_sample_in,
   input  wire logic                        fb_over_ov_in,
   input  wire logic                        fb_below_uv_in,
   input  wire logic                        fb_below_short_in,
   input  wire logic                        bus_above_brown_in_in,
   input  wire logic                        bus_below_brown_out_in,
   output logic                             gate_drive_out,
   output logic                             line_comp_switch_out,
   output logic                             high_ratio_out,
   output logic                             overtemp_latched_out,
   output flyback_fault_pkg::fault_t        fault_code_out,
   output flyback_fault_pkg::state_t        state_out
);
   import flyback_fault_pkg::*;

   localparam int UV_W = $clog2(UV_LIMIT + 1);
   localparam int SC_W = $clog2(SHORT_LIMIT + 1);

   state_t                 state,      next_state;
   fault_t                 fault,      next_fault;
   logic                   gate,       next_gate;
   logic                   ot_latch,   next_ot_latch;
   logic                   startup,    next_startup;
   logic                   max_seen,   next_max_seen;
   logic [BLANK_W-1:0]     blank,      next_blank;
   logic [CYC_CNT_W-1:0]   ov_cnt,     next_ov_cnt;
   logic [CYC_CNT_W-1:0]   sense_cnt,  next_sense_cnt;
   logic [CYC_CNT_W-1:0]   bo_cnt,     next_bo_cnt;
   logic [UV_W-1:0]        uv_tmr,     next_uv_tmr;
   logic [SC_W-1:0]        sc_tmr,     next_sc_tmr;
   logic                   pulse_end;
   logic                   active;

   // Sequencing, pulse gating and fault detection
   always_comb begin
      next_state     = state;
      next_fault     = fault;
      next_gate      = gate;
      next_startup   = startup;
      next_max_seen  = max_seen;
      next_blank     = blank;
      next_ov_cnt    = ov_cnt;
      next_sense_cnt = sense_cnt;
      next_bo_cnt    = bo_cnt;
      next_uv_tmr    = uv_tmr;
      next_sc_tmr    = sc_tmr;
      pulse_end      = 1'b0;
      active         = (state == ST_RUN) || (state == ST_CHECK_PULSE);
      // Set wins over the hysteresis release
      next_ot_latch  = overtemp_in || (ot_latch && !temp_recovered_in); // [R07]

      // Pulse: turn-off only after blanking ends
      if (gate) begin
         if (blank != '0) begin
            next_blank = blank - 1'b1; // [R14]
         end else begin
            if (sense_max_in) begin
               next_max_seen = 1'b1;
            end
            if (sense_ref_trip_in) begin
               next_gate = 1'b0; // [R14]
               pulse_end = 1'b1;
            end
         end
      end else if (state == ST_RUN && pulse_request_in) begin
         next_gate     = 1'b1;
         next_blank    = BLANK_W'(BLANK_CYCLES);
         next_max_seen = 1'b0;
      end

      // Per-cycle counters, bus sampled on the last on cycle
      if (state == ST_RUN) begin
         if (pulse_end) begin
            next_sense_cnt = (max_seen || sense_max_in) ?
                             sense_cnt + 1'b1 : '0; // [R05]
            next_bo_cnt = bus_below_brown_out_in ?
                          bo_cnt + 1'b1 : '0; // [R09] [R12]
         end
         if (fb_sample_in) begin
            next_ov_cnt = fb_over_ov_in ? ov_cnt + 1'b1 : '0; // [R02]
            if (!fb_below_uv_in) begin
               next_startup = 1'b0; // [R15]
            end
         end
         // Time-based timers restart when the condition drops
         next_uv_tmr = fb_below_uv_in ? uv_tmr + 1'b1 : '0; // [R03] [R17]
         next_sc_tmr = fb_below_short_in ? sc_tmr + 1'b1 : '0; // [R04] [R17]
      end

      case (state)
         ST_WAIT_START: begin
            // Over-temperature latch blocks the start pulse
            if (startup_supply_in && !ot_latch && !overtemp_in) begin // [R07]
               next_state    = ST_CHECK_PULSE; // [R10]
               next_gate     = 1'b1;
               next_blank    = BLANK_W'(BLANK_CYCLES);
               next_max_seen = 1'b0;
            end
         end
         ST_CHECK_PULSE: begin
            // Single probe pulse judged at its end
            if (pulse_end) begin
               if (bus_above_brown_in_in) begin
                  next_state   = ST_RUN; // [R10]
                  next_startup = 1'b1; // [R15]
               end else begin
                  next_state = ST_BROWN_FAIL; // [R11]
               end
            end
         end
         ST_RUN: begin
         end
         ST_BROWN_FAIL, ST_RECOVER: begin
            // Stay off until supply decays, then restart clean
            next_gate = 1'b0;
            if (min_supply_in) begin
               next_state     = ST_WAIT_START; // [R08] [R11]
               next_fault     = FAULT_NONE; // [R16]
               next_ov_cnt    = '0;
               next_sense_cnt = '0;
               next_bo_cnt    = '0;
               next_uv_tmr    = '0;
               next_sc_tmr    = '0;
               next_startup   = 1'b0;
            end
         end
         default: begin
            next_state = ST_RECOVER;
            next_gate  = 1'b0;
         end
      endcase

      // Trips in priority order; fault stays latched until restart
      if (state != ST_RECOVER && state != ST_BROWN_FAIL) begin
         if (supply_overvoltage_in) begin
            next_fault = FAULT_SUPPLY_OV; // [R01]
         end else if (overtemp_in) begin
            next_fault = FAULT_OVERTEMP; // [R06]
         end else if (!active) begin
            next_fault = fault;
         end else if (next_sc_tmr == SC_W'(SHORT_LIMIT)) begin
            next_fault = FAULT_SHORT; // [R04]
         end else if (next_uv_tmr == UV_W'(UV_LIMIT)) begin
            next_fault = FAULT_OUT_UV; // [R03]
         end else if (next_ov_cnt == CYC_CNT_W'(OV_COUNT)) begin
            next_fault = FAULT_OUT_OV; // [R02]
         end else if (next_sense_cnt == CYC_CNT_W'(SENSE_MAX_COUNT)) begin
            next_fault = FAULT_SENSE_MAX; // [R05]
         end else if (next_bo_cnt == CYC_CNT_W'(BROWN_OUT_COUNT)) begin
            next_fault = FAULT_BROWN_OUT; // [R12]
         end
         if (next_fault != FAULT_NONE) begin
            next_state = ST_RECOVER; // [R08]
            next_gate  = 1'b0; // [R01] [R06]
         end
      end
   end

   // State registers
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         state     <= ST_WAIT_START;
         fault     <= FAULT_NONE;
         gate      <= 1'b0;
         ot_latch  <= 1'b0;
         startup   <= 1'b0;
         max_seen  <= 1'b0;
         blank     <= '0;
         ov_cnt    <= '0;
         sense_cnt <= '0;
         bo_cnt    <= '0;
         uv_tmr    <= '0;
         sc_tmr    <= '0;
      end else begin
         state     <= next_state;
         fault     <= next_fault;
         gate      <= next_gate;
         ot_latch  <= next_ot_latch;
         startup   <= next_startup;
         max_seen  <= next_max_seen;
         blank     <= next_blank;
         ov_cnt    <= next_ov_cnt;
         sense_cnt <= next_sense_cnt;
         bo_cnt    <= next_bo_cnt;
         uv_tmr    <= next_uv_tmr;
         sc_tmr    <= next_sc_tmr;
      end
   end

   // Outputs; compensation switch follows primary on time
   assign gate_drive_out       = gate;
   assign line_comp_switch_out = gate; // [R13]
   assign high_ratio_out       = startup; // [R15]
   assign overtemp_latched_out = ot_latch;
   assign fault_code_out       = fault;
   assign state_out            = state;

   // Checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);

   supply_ov_off_a: assert property ( // [R01]
      supply_overvoltage_in |=> !gate && state == ST_RECOVER)
      else $error("drive not stopped on supply over-voltage");
   overtemp_off_a: assert property ( // [R06]
      overtemp_in |=> !gate && ot_latch && state != ST_RUN)
      else $error("drive not stopped on over-temperature");
   ov_count_a: assert property ( // [R02]
      state == ST_RUN && fb_sample_in && fb_over_ov_in && ov_cnt == 2'h2
      |=> state == ST_RECOVER && !gate)
      else $error("output over-voltage did not trip on third sample");
   uv_timer_a: assert property ( // [R03]
      state == ST_RUN && fb_below_uv_in && uv_tmr == UV_W'(UV_LIMIT - 1)
      |=> state == ST_RECOVER)
      else $error("under-voltage timer did not trip");
   short_timer_a: assert property ( // [R04]
      state == ST_RUN && fb_below_short_in
      && sc_tmr == SC_W'(SHORT_LIMIT - 1) |=> fault == FAULT_SHORT
      || fault == FAULT_SUPPLY_OV || fault == FAULT_OVERTEMP)
      else $error("short timer did not trip");
   timer_reset_a: assert property ( // [R17]
      state == ST_RUN && !fb_below_uv_in && !fb_below_short_in
      |=> uv_tmr == '0 && sc_tmr == '0)
      else $error("fault timer not reset");
   ot_hold_a: assert property ( // [R07]
      ot_latch && !temp_recovered_in && state == ST_WAIT_START
      |=> (!gate)[*2])
      else $error("pulse issued while over-temperature latched");
   recover_hold_a: assert property ( // [R08]
      state == ST_RECOVER && !min_supply_in |=> !gate && state == ST_RECOVER)
      else $error("left recovery before minimum supply");
   restart_clear_a: assert property ( // [R16]
      state == ST_RECOVER && min_supply_in |=> fault == FAULT_NONE
      && ov_cnt == '0 && uv_tmr == '0 && state == ST_WAIT_START)
      else $error("restart did not clear fault state");
   brown_in_fail_a: assert property ( // [R11]
      state == ST_CHECK_PULSE && pulse_end && !bus_above_brown_in_in
      |=> state == ST_BROWN_FAIL ##1 !gate)
      else $error("failed brown-in check kept switching");
   // Start threshold launches exactly one probe pulse
   probe_pulse_a: assert property ( // [R10]
      state == ST_WAIT_START && startup_supply_in && !ot_latch
      && !overtemp_in && !supply_overvoltage_in
      |=> gate && state == ST_CHECK_PULSE)
      else $error("no probe pulse at start threshold");
   probe_single_a: assert property ( // [R10]
      state == ST_CHECK_PULSE && pulse_end |=> !gate)
      else $error("probe pulse not ended after its check");
   // Only a fault shutdown may cut a pulse inside blanking
   blanking_a: assert property ( // [R14]
      gate && blank != '0 |=> gate || state == ST_RECOVER)
      else $error("pulse ended inside blanking time");
   line_comp_a: assert property ( // [R13]
      line_comp_switch_out == gate_drive_out
      && (!gate || state == ST_RUN || state == ST_CHECK_PULSE))
      else $error("compensation switch closed outside on time");
   // Pulse counters trip on the third bad pulse in a row
   sense_count_a: assert property ( // [R05]
      state == ST_RUN && pulse_end && (max_seen || sense_max_in)
      && sense_cnt == CYC_CNT_W'(SENSE_MAX_COUNT - 1)
      |=> state == ST_RECOVER && !gate)
      else $error("sense maximum did not trip on third pulse");
   brown_out_a: assert property ( // [R12]
      state == ST_RUN && pulse_end && bus_below_brown_out_in
      && bo_cnt == CYC_CNT_W'(BROWN_OUT_COUNT - 1)
      |=> state == ST_RECOVER && !gate)
      else $error("brown-out did not trip on third pulse");

   run_seen_c: cover property (state == ST_CHECK_PULSE ##[1:100]
      state == ST_RUN);
   recover_seen_c: cover property (state == ST_RUN ##1 state == ST_RECOVER);
   brown_fail_c: cover property (state == ST_BROWN_FAIL);
   sense_trip_c: cover property (fault == FAULT_SENSE_MAX);
   ot_block_c: cover property (ot_latch && state == ST_WAIT_START
      && startup_supply_in);
endmodule : flyback_fault_protection_fsm

// file: switch_sense_model.sv
`timescale 1ns/100ps

// Power switch and sense comparators on the far side of the sequencer
module switch_sense_model (
   input  wire logic       sys_clk_in,
   input  wire logic       gate_in,
   input  wire logic [7:0] ramp_in,
   input  wire logic       over_current_in,
   input  wire logic       bus_low_in,
   output logic            sense_ref_trip_out,
   output logic            sense_max_out,
   output logic            bus_above_brown_in_out,
   output logic            bus_below_brown_out_out
);
   logic [7:0] on_cycles;

   // Primary current ramps only while the switch conducts
   always_ff @(posedge sys_clk_in) begin
      on_cycles <= gate_in ? on_cycles + 8'h01 : 8'h00;
   end

   // Comparators read low with the switch open; early trips test blanking
   assign sense_ref_trip_out = gate_in && (on_cycles >= ramp_in);
   assign sense_max_out      = gate_in && over_current_in;
   // Bus level seen on the feedback pin during on time only
   assign bus_above_brown_in_out  = gate_in && !bus_low_in;
   assign bus_below_brown_out_out = gate_in && bus_low_in;
endmodule : switch_sense_model

// file: flyback_fault_protection_fsm_tb.sv
`timescale 1ns/100ps

`define CHK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("wrong value at %0t: got %0h expected %0h", \
                  $time, got, exp); \
      end \
   end

module flyback_fault_protection_fsm_tb;
   import flyback_fault_pkg::*;
   localparam int UV_LIM    = 20;
   localparam int SHORT_LIM = 10;
   logic sys_clk_in = 1'b0, srst_in = 1'b1, supply_overvoltage_in = 1'b0;
   logic startup_supply_in = 1'b0, min_supply_in = 1'b0, overtemp_in = 1'b0;
   logic temp_recovered_in = 1'b0, pulse_request_in = 1'b0;
   logic fb_sample_in = 1'b0, fb_over_ov_in = 1'b0, fb_below_uv_in = 1'b0;
   logic fb_below_short_in = 1'b0, over_cur = 1'b0, bus_low = 1'b0;
   logic [7:0] ramp = 8'h0A;
   logic sense_ref_trip, sense_max, bus_above, bus_below;
   logic gate_drive_out, line_comp_switch_out, high_ratio_out;
   logic overtemp_latched_out;
   fault_t fault_code_out;
   state_t state_out;
   int num_errors = 0;
   int tests_run  = 0;

   always #20 sys_clk_in = ~sys_clk_in;

   flyback_fault_protection_fsm #(.UV_LIMIT(UV_LIM), .SHORT_LIMIT(SHORT_LIM))
   u_flyback_fault_protection_fsm (
      .sys_clk_in(sys_clk_in), .srst_in(srst_in),
      .supply_overvoltage_in(supply_overvoltage_in),
      .startup_supply_in(startup_supply_in), .min_supply_in(min_supply_in),
      .overtemp_in(overtemp_in), .temp_recovered_in(temp_recovered_in),
      .pulse_request_in(pulse_request_in), .sense_ref_trip_in(sense_ref_trip),
      .sense_max_in(sense_max), .fb_sample_in(fb_sample_in),
      .fb_over_ov_in(fb_over_ov_in), .fb_below_uv_in(fb_below_uv_in),
      .fb_below_short_in(fb_below_short_in),
      .bus_above_brown_in_in(bus_above), .bus_below_brown_out_in(bus_below),
      .gate_drive_out(gate_drive_out),
      .line_comp_switch_out(line_comp_switch_out),
      .high_ratio_out(high_ratio_out),
      .overtemp_latched_out(overtemp_latched_out),
      .fault_code_out(fault_code_out), .state_out(state_out));

   switch_sense_model u_switch_sense_model (
      .sys_clk_in(sys_clk_in), .gate_in(gate_drive_out), .ramp_in(ramp),
      .over_current_in(over_cur), .bus_low_in(bus_low),
      .sense_ref_trip_out(sense_ref_trip), .sense_max_out(sense_max),
      .bus_above_brown_in_out(bus_above),
      .bus_below_brown_out_out(bus_below));

   task automatic tick(int n = 1);
      repeat (n) @(posedge sys_clk_in);
   endtask : tick

   task automatic tally_and_finish();
      $display("errors %0d in %0d checks", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   task automatic wait_gate(logic v);
      int n;
      n = 0;
      while (gate_drive_out !== v && n < 100) begin
         tick();
         #1;
         n++;
      end
   endtask : wait_gate

   // Counts the cycles the switch stays on; request drops after launch
   task automatic measure(output int len);
      len = 0;
      `CHK(line_comp_switch_out, 1'b1)
      while (gate_drive_out === 1'b1 && len < 300) begin
         len++;
         tick();
         pulse_request_in <= 1'b0;
         #1;
      end
      `CHK(line_comp_switch_out, 1'b0)
   endtask : measure

   task automatic run_pulse(int exp_len, logic over, logic low);
      int len;
      tick();
      pulse_request_in <= 1'b1;
      over_cur         <= over;
      bus_low          <= low;
      #1;
      wait_gate(1'b1);
      measure(len);
      `CHK(len, exp_len)
   endtask : run_pulse

   task automatic probe(logic ok);
      int len;
      tick();
      bus_low           <= !ok;
      startup_supply_in <= 1'b1;
      #1;
      wait_gate(1'b1);
      `CHK(state_out, ST_CHECK_PULSE)
      measure(len);
      `CHK(len, 12)
      `CHK(state_out, ok ? ST_RUN : ST_BROWN_FAIL)
      `CHK(high_ratio_out, ok)
      tick(3);
      #1;
      `CHK(gate_drive_out, 1'b0)
   endtask : probe

   // Supply decays to minimum; supply over-voltage, over-temperature, under-voltage and short sources are released with it
   task automatic restart();
      tick();
      startup_supply_in     <= 1'b0;
      min_supply_in         <= 1'b1;
      fb_below_uv_in        <= 1'b0;
      fb_below_short_in     <= 1'b0;
      supply_overvoltage_in <= 1'b0;
      overtemp_in           <= 1'b0;
      tick();
      min_supply_in <= 1'b0;
      #1;
      `CHK(state_out, ST_WAIT_START)
      `CHK(fault_code_out, FAULT_NONE)
   endtask : restart

   task automatic expect_trip(fault_t f, int limit);
      int n;
      n = 0;
      while (state_out !== ST_RECOVER && n < limit) begin
         tick();
         #1;
         n++;
      end
      `CHK(fault_code_out, f)
      tick(6);
      #1;
      `CHK(state_out, ST_RECOVER)
      `CHK(gate_drive_out, 1'b0)
      `CHK(fault_code_out, f)
      restart();
      probe(1'b1);
   endtask : expect_trip

   task automatic fb_sample(logic ov, logic uv);
      tick();
      fb_sample_in   <= 1'b1;
      fb_over_ov_in  <= ov;
      fb_below_uv_in <= uv;
      tick();
      fb_sample_in   <= 1'b0;
      fb_over_ov_in  <= 1'b0;
      fb_below_uv_in <= 1'b0;
      #1;
   endtask : fb_sample

   // Two bad pulses, one good, two bad, then the third bad in a row
   task automatic series(logic over, logic low, fault_t f);
      for (int i = 0; i < 5; i++) begin
         run_pulse(12, over && i != 2, low && i != 2);
      end
      `CHK(state_out, ST_RUN)
      run_pulse(12, over, low);
      expect_trip(f, 2);
      over_cur <= 1'b0;
      bus_low  <= 1'b0;
   endtask : series

   // Level fault held two cycles short of a trip, dropped, then held on
   task automatic timer_trip(int lim, logic short, fault_t f);
      for (int i = 0; i < 2; i++) begin
         tick();
         fb_below_uv_in    <= !short;
         fb_below_short_in <= short;
         tick(lim - 2);
         fb_below_uv_in    <= i == 1 && !short;
         fb_below_short_in <= i == 1 && short;
         #1;
         `CHK(state_out, ST_RUN)
      end
      expect_trip(f, 4);
   endtask : timer_trip

   // Watchdog sized well beyond the full sequence
   initial begin
      tick(20000);
      num_errors++;
      tally_and_finish();
   end

   initial begin
      int len;
      tick(6);
      srst_in <= 1'b0;
      #1;
      `CHK(gate_drive_out, 1'b0)
      probe(1'b0);
      restart();
      probe(1'b0);
      restart();
      probe(1'b1);
      fb_sample(1'b0, 1'b1);
      `CHK(high_ratio_out, 1'b1)
      fb_sample(1'b0, 1'b0);
      `CHK(high_ratio_out, 1'b0)
      tick();
      ramp <= 8'h02;
      run_pulse(12, 1'b0, 1'b0);
      tick();
      ramp <= 8'h1E;
      run_pulse(31, 1'b0, 1'b0);
      tick();
      ramp <= 8'h0A;
      for (int i = 0; i < 5; i++) fb_sample(i != 2, 1'b0);
      `CHK(state_out, ST_RUN)
      fb_sample(1'b1, 1'b0);
      expect_trip(FAULT_OUT_OV, 2);
      series(1'b1, 1'b0, FAULT_SENSE_MAX);
      series(1'b0, 1'b1, FAULT_BROWN_OUT);
      timer_trip(UV_LIM, 1'b0, FAULT_OUT_UV);
      timer_trip(SHORT_LIM, 1'b1, FAULT_SHORT);
      tick();
      pulse_request_in <= 1'b1;
      #1;
      wait_gate(1'b1);
      tick(3);
      supply_overvoltage_in <= 1'b1;
      pulse_request_in      <= 1'b0;
      tick();
      #1;
      `CHK(gate_drive_out, 1'b0)
      `CHK(state_out, ST_RECOVER)
      expect_trip(FAULT_SUPPLY_OV, 0);
      tick();
      overtemp_in <= 1'b1;
      tick();
      #1;
      `CHK(state_out, ST_RECOVER)
      `CHK(fault_code_out, FAULT_OVERTEMP)
      restart();
      tick();
      startup_supply_in <= 1'b1;
      tick(20);
      #1;
      `CHK(gate_drive_out, 1'b0)
      `CHK(overtemp_latched_out, 1'b1)
      tick();
      temp_recovered_in <= 1'b1;
      #1;
      wait_gate(1'b1);
      measure(len);
      `CHK(state_out, ST_RUN)
      `CHK(overtemp_latched_out, 1'b0)
      tally_and_finish();
   end
endmodule : flyback_fault_protection_fsm_tb
